// *** tb/hdpm_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module hdpm_dev_model (
	// Clock
	input wire logic clk,
	// Per port {dp, dm} idle level of the attached device, 00 when vacant
	input wire logic [13:0] attach,
	// Downstream lines
	output logic [13:0] line
);
	// pull-downs and device pull-ups
	// A vacant port is pulled to SE0; a pull-up on one line sets the speed
	always @(posedge clk)
		line <= attach;
endmodule
`default_nettype wire

// *** tb/hdpm_top_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module hdpm_chk #(
	parameter NPORTS = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port and USB events
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic eof1,
	input wire logic bus_reset,
	input wire logic suspended,
	input wire logic packet_active,
	// Forwarding and interrupt
	input wire logic [NPORTS-1:0] down_fwd_en,
	input wire logic [NPORTS-1:0] up_fwd_en,
	input wire logic [NPORTS-1:0] eop_drive,
	input wire logic hub_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Read of the connect, enable or speed register
	sequence s_rd_reg;
		reg_rd && reg_addr >= 8'h48 && reg_addr <= 8'h4a;
	endsequence
	// Three edges cover the write, enable and forwarding register stages
	sequence s_pkt;
		packet_active [*3];
	endsequence
	// Read data stands only in the cycle after a read strobe
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_rd_bit7: assert property (s_rd_reg |=> !reg_rdata[7])
		else $error("reserved bit set");
	a_eop_cause: assert property (eop_drive != 0 |-> $past(eof1))
		else $error("end of packet without frame point");
	a_eop_pulse: assert property (eop_drive != 0 |=> eop_drive == 0)
		else $error("end of packet too long");
	a_irq_pulse: assert property (hub_irq |=> !hub_irq)
		else $error("interrupt longer than one cycle");
	a_susp_block: assert property (suspended ##1 suspended |-> down_fwd_en == 0 && up_fwd_en == 0)
		else $error("traffic while suspended");
	// Forwarding lags the enable register by one stage
	a_bus_rst: assert property (bus_reset |-> ##2 down_fwd_en == 0)
		else $error("port open after bus reset");
	// A deferred enable must not appear mid packet
	a_pkt_defer: assert property (s_pkt |-> (down_fwd_en & ~$past(down_fwd_en)) == 0)
		else $error("port opened mid packet");
endmodule
bind hdpm_top hdpm_chk #(.NPORTS(NPORTS)) u_chk (.clk, .reset, .reg_addr, .reg_rd, .reg_rdata, .eof1,
	.bus_reset, .suspended, .packet_active, .down_fwd_en, .up_fwd_en, .eop_drive, .hub_irq);
`default_nettype wire

// *** tb/hdpm_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module hdpm_top_tb;
	logic clk, reset, reg_wr, reg_rd, bus_reset, suspended, eof1, eof2, packet_active, up_full_speed, resume_evt;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [6:0] port_forced, port_busy, down_fwd_en, up_fwd_en, eop_drive, hub_addr, func_addr;
	logic [13:0] attach, dn_line;
	logic hub_irq;
	int err_count = 0, tests_run = 0, irq_cnt = 0;
	// Clock and interrupt tally
	always #5 clk = ~clk;
	always @(posedge clk)
		if (hub_irq === 1'b1)
			irq_cnt++;
	hdpm_top #(.NPORTS(7)) DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_reset,
		.suspended, .eof1, .eof2, .packet_active, .up_full_speed, .resume_evt, .port_forced, .port_busy,
		.dn_line, .down_fwd_en, .up_fwd_en, .eop_drive, .hub_addr, .func_addr, .hub_irq);
	hdpm_dev_model PM (.clk, .attach, .line(dn_line));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic t_regs;
		rd(8'h48, 8'h00);
		rd(8'h49, 8'h00);
		rd(8'h4a, 8'h00);
		rd(8'h7f, 8'h00);
		// Addresses are loaded once the status stage has completed
		wr(8'h50, 8'h05);
		wr(8'h51, 8'h0a);
		#1 chk({1'b0, hub_addr}, 8'h05);
		chk({1'b0, func_addr}, 8'h0a);
		wr(8'h52, 8'h01);
	endtask
	// Port 1 full speed, port 2 low speed, read just before and after the filter time
	task automatic t_conn;
		int n;
		n = irq_cnt;
		attach <= 14'h0006;
		repeat (240) @(posedge clk);
		rd(8'h48, 8'h00);
		repeat (20) @(posedge clk);
		rd(8'h48, 8'h03);
		rd(8'h4a, 8'h02);
		// Both ports settle in the same cycle, so exactly one pulse
		chk(8'(irq_cnt - n), 8'h01);
	endtask
	task automatic t_enable;
		{packet_active, up_full_speed} <= 2'b11;
		wr(8'h49, 8'h03);
		repeat (3) @(posedge clk);
		chk({1'b0, down_fwd_en}, 8'h00);
		packet_active <= 1'b0;
		repeat (3) @(posedge clk);
		chk({1'b0, down_fwd_en}, 8'h01);
		chk({1'b0, up_fwd_en}, 8'h03);
		eof1 <= 1'b1;
		@(posedge clk);
		eof1 <= 1'b0;
		#1 chk({1'b0, eop_drive}, 8'h03);
	endtask
	// Port 1 still busy at the second frame point loses its enable; babble irq is off, resume on
	task automatic t_babble;
		int n;
		n = irq_cnt;
		{port_busy, eof2} <= {7'h01, 1'b1};
		@(posedge clk);
		{port_busy, eof2} <= 8'h00;
		rd(8'h49, 8'h02);
		wr(8'h52, 8'h05);
		resume_evt <= 1'b1;
		@(posedge clk);
		resume_evt <= 1'b0;
		repeat (3) @(posedge clk);
		chk(8'(irq_cnt - n), 8'h01);
		wr(8'h52, 8'h01);
	endtask
	// Port 1, disabled by babble, detaches while suspended
	task automatic t_susp;
		int n;
		n = irq_cnt;
		suspended <= 1'b1;
		attach <= 14'h0004;
		repeat (190) @(posedge clk);
		chk({1'b0, down_fwd_en}, 8'h00);
		chk({1'b0, up_fwd_en}, 8'h00);
		rd(8'h48, 8'h03);
		repeat (55) @(posedge clk);
		rd(8'h48, 8'h02);
		chk(8'(irq_cnt - n), 8'h01);
		suspended <= 1'b0;
	endtask
	// Bus reset clears connect, enable and speed; the filters then see port 2 again, forced so no interrupt
	task automatic t_busrst;
		int n;
		n = irq_cnt;
		{up_full_speed, port_forced} <= 8'h7f;
		bus_reset <= 1'b1;
		@(posedge clk);
		bus_reset <= 1'b0;
		rd(8'h48, 8'h00);
		rd(8'h49, 8'h00);
		rd(8'h4a, 8'h00);
		repeat (250) @(posedge clk);
		rd(8'h48, 8'h02);
		chk(8'(irq_cnt - n), 8'h00);
		port_forced <= 7'h00;
		wr(8'h4a, 8'h02);
		wr(8'h49, 8'h02);
		rd(8'h49, 8'h02);
		#1 chk({1'b0, down_fwd_en}, 8'h02);
	endtask
	task automatic final_report;
		$display("err_count %0d tests_run %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Every wait is a fixed count, so the run cannot hang
	initial
	begin
		{clk, reg_wr, reg_rd, bus_reset, suspended, eof1, eof2, packet_active, up_full_speed, resume_evt} = '0;
		{reg_addr, reg_wdata, port_forced, port_busy, attach} = '0;
		reset = 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_conn;
		t_enable;
		t_babble;
		t_susp;
		t_busrst;
		final_report;
	end
endmodule
`default_nettype wire

// *** verilog/hdpm_port_filter.v ***
`timescale 1ns/10ps
`default_nettype none
`include "hdpm_regs.vh"
module hdpm_port_filter #(
	parameter CW = 9
) (
	// Clock and resets
	input wire clk,
	input wire reset,
	input wire bus_reset,
	// Line state {dp, dm}
	input wire [1:0] line,
	// Results
	output reg connected_reg,
	output reg low_speed_reg,
	output reg change_reg
);
	reg [1:0] last_reg;
	reg [CW-1:0] count_reg;
	// Thresholds cut to the counter width; both fit with room to spare
	localparam integer CONN_INT = `HDPM_CONNECT_CYC;
	localparam integer DISC_INT = `HDPM_DISC_CYC;
	localparam [CW-1:0] CONN_CYC = CONN_INT[CW-1:0];
	localparam [CW-1:0] DISC_CYC = DISC_INT[CW-1:0];
	wire se0 = (line == `HDPM_SE0);
	// [R21] restart on change
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			last_reg <= 2'h0;
			count_reg <= {CW{1'b0}};
		end
		// Bus reset restarts the timer, else a saturated count never meets the threshold again
		else if (bus_reset || line != last_reg)
		begin
			last_reg <= line;
			count_reg <= {CW{1'b0}};
		end
		else if (count_reg != {CW{1'b1}})
			count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
	end
	// Connect and disconnect decisions; bus reset forces a fresh look
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			connected_reg <= 1'b0;
			low_speed_reg <= 1'b0;
			change_reg <= 1'b0;
		end
		else
		begin
			change_reg <= 1'b0;
			if (bus_reset)
			begin
				connected_reg <= 1'b0;
				low_speed_reg <= 1'b0;
			end
			// [R05] connect after 2.5 us
			else if (!connected_reg && !se0 && line == last_reg && count_reg == CONN_CYC)
			begin
				connected_reg <= 1'b1;
				change_reg <= 1'b1;
				// [R03] [R04] speed from idle
				low_speed_reg <= (line == `HDPM_LS_J);
			end
			// [R01] [R06] SE0 means detach
			else if (connected_reg && se0 && line == last_reg && count_reg == DISC_CYC)
			begin
				connected_reg <= 1'b0;
				change_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/hdpm_regs.vh ***
// Notes on behaviour
// [R01] Both data lines low on a port means nothing is attached.
// [R02] Drive an end-of-packet downstream at the EOF1 point of each frame.
// [R03] D+ low, D- high: set connected flag, raise hub interrupt.
// [R04] D+ high, D- low: set connected, clear speed flag, raise hub interrupt.
// [R05] Register a connect only after non-SE0 persists longer than 2.5 us.
// [R06] SE0 for 2.0 to 2.5 us means disconnect: clear flag, interrupt.
// [R07] Connect status holds one flag per port in bits 0 to 6.
// [R08] Connect status clears on reset or bus reset; bit 7 reads zero.
// [R09] Speed register: 1 low speed, 0 full speed; clears on resets; bit 7 zero.
// [R10] Firmware writes the right speed bit when resetting a port.
// [R11] Firmware sets the enable bit; the port then passes traffic both ways.
// [R12] Enabled unsuspended ports get upstream traffic; their traffic goes up unless babbling.
// [R13] Low-speed ports get no full-speed upstream traffic.
// [R14] A new enable waits for the current packet end; idle bus enables at once.
// [R15] In suspend, connect or disconnect on any port interrupts if enabled.
// [R16] Firmware loads a new device address only after the status stage.
// [R17] Two device addresses: hub and compound function in the second slot.
// [R18] Babble and resume interrupt only when enabled; forced ports never interrupt (the logic masks only their connect changes).
// [R19] Hardware clears a port enable on babble seen at EOF2.
// [R20] Port enable register clears on reset or bus reset.
// [R21] Filters are per-port counters restarted on every line state change.
// [R22] Each hub event yields one interrupt pulse combined across ports.
`ifndef HDPM_REGS_VH
`define HDPM_REGS_VH
`define HDPM_ADDR_CONNECT 8'h48
`define HDPM_ADDR_ENABLE 8'h49
`define HDPM_ADDR_SPEED 8'h4a
`define HDPM_ADDR_ADDR_HUB 8'h50
`define HDPM_ADDR_ADDR_FUNC 8'h51
`define HDPM_ADDR_IRQ_CTRL 8'h52
`define HDPM_RESET_VALUE 8'h00
`define HDPM_IRQEN_HUB 0
`define HDPM_IRQEN_BABBLE 1
`define HDPM_IRQEN_RESUME 2
`define HDPM_CLK_MHZ 100
`define HDPM_CONNECT_NS 2500
`define HDPM_DISC_NS 2000
`define HDPM_CONNECT_CYC ((`HDPM_CONNECT_NS * `HDPM_CLK_MHZ) / 1000 + 1)
`define HDPM_DISC_CYC ((`HDPM_DISC_NS * `HDPM_CLK_MHZ + 999) / 1000)
`define HDPM_LS_J 2'b01
`define HDPM_FS_J 2'b10
`define HDPM_SE0 2'b00
`endif

// *** verilog/hdpm_top.v ***
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "hdpm_regs.vh"
module hdpm_top #(
	parameter NPORTS = 7
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// USB side events
	input wire bus_reset,
	input wire suspended,
	input wire eof1,
	input wire eof2,
	input wire packet_active,
	input wire up_full_speed,
	input wire resume_evt,
	input wire [NPORTS-1:0] port_forced,
	input wire [NPORTS-1:0] port_busy,
	// Downstream line states, two bits per port {dp, dm}
	input wire [2*NPORTS-1:0] dn_line,
	// Forwarding
	output reg [NPORTS-1:0] down_fwd_en,
	output reg [NPORTS-1:0] up_fwd_en,
	output reg [NPORTS-1:0] eop_drive,
	// Device addresses
	output reg [6:0] hub_addr,
	output reg [6:0] func_addr,
	// Interrupt request pulse
	output reg hub_irq
);
	reg [NPORTS-1:0] speed_reg;
	reg [NPORTS-1:0] enable_reg;
	reg [NPORTS-1:0] pend_reg;
	reg [NPORTS-1:0] babble_reg;
	reg [2:0] irq_en_reg;
	wire [NPORTS-1:0] conn;
	wire [NPORTS-1:0] lsd;
	wire [NPORTS-1:0] chg;
	genvar i;
	generate
		for (i = 0; i < NPORTS; i = i + 1)
		begin : g_port
			hdpm_port_filter #(.CW(9)) u_filt (
				.clk(clk),
				.reset(reset),
				.bus_reset(bus_reset),
				.line(dn_line[2*i+1:2*i]),
				.connected_reg(conn[i]),
				.low_speed_reg(lsd[i]),
				.change_reg(chg[i])
			);
		end
	endgenerate
	wire wr_en = reg_wr && reg_addr == `HDPM_ADDR_ENABLE;
	// Babble: traffic still active at EOF2 on an enabled port
	wire [NPORTS-1:0] babble = (eof2 ? port_busy : {NPORTS{1'b0}}) & enable_reg;
	// Register writes and hardware updates
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			speed_reg <= {NPORTS{1'b0}};
			enable_reg <= {NPORTS{1'b0}};
			pend_reg <= {NPORTS{1'b0}};
			babble_reg <= {NPORTS{1'b0}};
			irq_en_reg <= 3'h0;
			hub_addr <= 7'h00;
			func_addr <= 7'h00;
		end
		// [R08] [R09] [R20] bus reset clears
		else if (bus_reset)
		begin
			speed_reg <= {NPORTS{1'b0}};
			enable_reg <= {NPORTS{1'b0}};
			pend_reg <= {NPORTS{1'b0}};
			babble_reg <= {NPORTS{1'b0}};
		end
		else
		begin
			// [R04] full-speed attach clears speed; [R03] low-speed sets it
			speed_reg <= (speed_reg & ~chg) | (chg & conn & lsd);
			if (reg_wr && reg_addr == `HDPM_ADDR_SPEED)
				speed_reg <= reg_wdata[NPORTS-1:0];
			// [R14] defer enables during a packet
			if (wr_en && packet_active)
			begin
				pend_reg <= reg_wdata[NPORTS-1:0];
				enable_reg <= (enable_reg & reg_wdata[NPORTS-1:0]) & ~babble;
			end
			else if (wr_en)
			begin
				pend_reg <= {NPORTS{1'b0}};
				enable_reg <= reg_wdata[NPORTS-1:0] & ~babble;
			end
			else if (!packet_active && pend_reg != {NPORTS{1'b0}})
			begin
				enable_reg <= (enable_reg | pend_reg) & ~babble;
				pend_reg <= {NPORTS{1'b0}};
			end
			// [R19] babble disables port
			else
				enable_reg <= enable_reg & ~babble;
			babble_reg <= babble;
			if (reg_wr && reg_addr == `HDPM_ADDR_IRQ_CTRL)
				irq_en_reg <= reg_wdata[2:0];
			// [R17] two address slots
			if (reg_wr && reg_addr == `HDPM_ADDR_ADDR_HUB)
				hub_addr <= reg_wdata[6:0];
			if (reg_wr && reg_addr == `HDPM_ADDR_ADDR_FUNC)
				func_addr <= reg_wdata[6:0];
		end
	end
	// Read data one cycle after the strobe; unmapped reads as zero
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= `HDPM_RESET_VALUE;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		// [R07] [R08] bit 7 reads zero
		else if (reg_addr == `HDPM_ADDR_CONNECT)
			reg_rdata <= {1'b0, conn};
		else if (reg_addr == `HDPM_ADDR_ENABLE)
			reg_rdata <= {1'b0, enable_reg};
		// [R09] speed readback
		else if (reg_addr == `HDPM_ADDR_SPEED)
			reg_rdata <= {1'b0, speed_reg};
		else if (reg_addr == `HDPM_ADDR_ADDR_HUB)
			reg_rdata <= {1'b0, hub_addr};
		else if (reg_addr == `HDPM_ADDR_ADDR_FUNC)
			reg_rdata <= {1'b0, func_addr};
		else if (reg_addr == `HDPM_ADDR_IRQ_CTRL)
			reg_rdata <= {5'h00, irq_en_reg};
		else
			reg_rdata <= 8'h00;
	end
	// Forwarding, EOF1 end-of-packet and the interrupt pulse
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			down_fwd_en <= {NPORTS{1'b0}};
			up_fwd_en <= {NPORTS{1'b0}};
			eop_drive <= {NPORTS{1'b0}};
			hub_irq <= 1'b0;
		end
		else
		begin
			// [R11] [R12] [R13] enabled ports pass traffic
			down_fwd_en <= suspended ? {NPORTS{1'b0}} :
				(enable_reg & ~(up_full_speed ? speed_reg : {NPORTS{1'b0}}));
			up_fwd_en <= suspended ? {NPORTS{1'b0}} : (enable_reg & ~babble_reg);
			// [R02] EOP at EOF1
			eop_drive <= eof1 ? enable_reg : {NPORTS{1'b0}};
			// [R15] [R18] [R22] gated combined pulse
			hub_irq <= (irq_en_reg[`HDPM_IRQEN_HUB] && ((chg & ~port_forced) != {NPORTS{1'b0}}))
				|| (irq_en_reg[`HDPM_IRQEN_BABBLE] && babble != {NPORTS{1'b0}})
				|| (irq_en_reg[`HDPM_IRQEN_RESUME] && resume_evt);
		end
	end
endmodule
`default_nettype wire
